// [sfi_pkg.sv]
/*
 holds constants shared by both ends of the flash identification link:
 command codes, header lengths, identity values and host timing.
 assumes a single 25 MHz system clock on both ends.
*/
`default_nettype none
package sfi_pkg;
   // system clock period
   localparam int CLK_PERIOD_NS = 40;

   // command codes
   localparam logic [7:0] CMD_WAKE_ID = 8'hab;
   localparam logic [7:0] CMD_MFR_DEV = 8'h90;
   localparam logic [7:0] CMD_UNIQUE = 8'h4b;
   localparam logic [7:0] CMD_STD_ID = 8'h9f;
   localparam logic [7:0] CMD_MODE_RST = 8'hff;

   // header lengths in clocks, command included
   localparam logic [5:0] HDR_WAKE_ID = 6'h20;
   localparam logic [5:0] HDR_MFR_DEV = 6'h20;
   localparam logic [5:0] HDR_UNIQUE = 6'h28;
   localparam logic [5:0] HDR_STD_ID = 6'h08;
   localparam logic [5:0] CMD_BITS = 6'h08;
   localparam logic [5:0] ADDR_LAST = 6'h1f;

   // clocks of ones that leave continuous mode, and the mode nibble that keeps it
   localparam logic [5:0] MODE_RST_QUAD = 6'h08;
   localparam logic [5:0] MODE_RST_DUAL = 6'h10;
   localparam logic [3:0] MODE_KEEP_NIBBLE = 4'ha;

   // identity values, all arbitrary
   localparam logic [7:0] ID_MFR = 8'h5a;
   localparam logic [7:0] ID_DEVICE = 8'h15;
   localparam logic [7:0] ID_MEM_TYPE = 8'h40;
   localparam logic [7:0] ID_CAPACITY = 8'h16;
   localparam logic [63:0] ID_UNIQUE = 64'h0123_4567_89ab_cdef;

   // host serial clock: half period in system clocks
   localparam logic [3:0] HALF_PERIOD = 4'h2;

   // chip select high time after each frame, covers both recoveries
   localparam int WAKE_RECOVERY_TIME_NS = 3000;
   localparam int WAKE_ID_RECOVERY_TIME_NS = 3000;
   localparam int RECOV_NS = (WAKE_RECOVERY_TIME_NS >
                              WAKE_ID_RECOVERY_TIME_NS) ?
                             WAKE_RECOVERY_TIME_NS : WAKE_ID_RECOVERY_TIME_NS;
   localparam int RECOV_INT = (RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] RECOV_CYCLES = RECOV_INT[11:0];

   // device frame states
   typedef enum logic [4:0] {
      DS_IDLE = 5'h01,
      DS_CMD = 5'h02,
      DS_HDR = 5'h04,
      DS_OUT = 5'h08,
      DS_DROP = 5'h10
   } sfi_dev_st_t;

   // identification kinds
   typedef enum logic [1:0] {
      OP_DEV = 2'h0,
      OP_MFR = 2'h1,
      OP_UID = 2'h2,
      OP_STD = 2'h3
   } sfi_op_t;

   // host states
   typedef enum logic [3:0] {
      HS_IDLE = 4'h1,
      HS_LEAD = 4'h2,
      HS_SHIFT = 4'h4,
      HS_GAP = 4'h8
   } sfi_host_st_t;
endpackage
`default_nettype wire

// [sfi_link_if.sv]
/*
 holds the serial link between host and flash ends.
 assumes both ends run on the same system clock; io1 is valid
 only while io1_oe is high.
*/
`timescale 1ns/1ps
`default_nettype none
interface sfi_link_if;
   logic cs_n;
   logic sclk;
   logic io0;
   logic io1;
   logic io1_oe;

   modport host (output cs_n, output sclk, output io0,
                 input io1, input io1_oe);
   modport flash (input cs_n, input sclk, input io0,
                  output io1, output io1_oe);
endinterface
`default_nettype wire

// [sfi_flash_end.sv]
/*
 holds the flash end: identification commands and continuous
 mode exit. assumes sclk, cs_n and io0 are synchronous to i_clk and
 that sclk stays at least two system clocks in each level.
*/
// What this block does
// [RULE1] device id byte repeats until chip select rises
// [RULE2] host keeps select high for recovery after wake
// [RULE3] wake/id command ignored while busy
// [RULE4] 90h, zero address: manufacturer then device byte
// [RULE5] address one swaps the byte order
// [RULE6] manufacturer and device bytes alternate endlessly
// [RULE7] 4Bh, four dummies, then 64-bit unique number
// [RULE8] 9Fh gives manufacturer, memory type, capacity
// [RULE9] Ax mode bits: next read starts at address
// [RULE10] continuous mode hides ordinary command codes
// [RULE11] host sends mode reset first after reset
// [RULE12] eight ones clear quad continuous mode
// [RULE13] sixteen ones clear dual continuous mode
// [RULE14] ABh plus three dummies before id byte
// [RULE15] power-down accepts only the wake command
// [RULE16] host bits sampled on rising clock edges
`timescale 1ns/1ps
`default_nettype none
module sfi_flash_end
   import sfi_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   sfi_link_if.flash link,
   input wire logic i_busy,
   input wire logic i_power_down,
   input wire logic i_mode_valid,
   input wire logic [7:0] i_mode_bits,
   input wire logic i_mode_dual,
   output logic o_wake,
   output logic o_cont_mode,
   output logic o_cont_frame
);
   sfi_dev_st_t st_q, st_d;
   sfi_op_t op_q, op_d;
   logic sclk_q;
   logic [5:0] cnt_q, cnt_d;
   logic [6:0] shift_q, shift_d;
   logic [6:0] out_cnt_q, out_cnt_d;
   logic io1_q, io1_d;
   logic oe_q, oe_d;
   logic addr_nz_q, addr_nz_d;
   logic swap_q, swap_d;
   logic cont_q, cont_d;
   logic dual_q, dual_d;
   logic wake_pend_q, wake_pend_d;
   logic wake_q, wake_d;
   logic frame_q, frame_d;
   logic rise, fall;
   logic [7:0] cmd;
   logic [5:0] cnt_inc;
   logic [5:0] hdr_len;
   logic [7:0] out_byte;
   logic out_bit;

   // edges of the serial clock
   assign rise = link.sclk & ~sclk_q;
   assign fall = ~link.sclk & sclk_q;
   assign cmd = {shift_q, link.io0};
   assign cnt_inc = cnt_q + 6'h01;

   // header length of the current command
   always_comb begin
      case (op_q)
         OP_DEV: hdr_len = HDR_WAKE_ID; // RULE14
         OP_MFR: hdr_len = HDR_MFR_DEV; // RULE4
         OP_UID: hdr_len = HDR_UNIQUE; // RULE7
         default: hdr_len = HDR_STD_ID;
      endcase
   end

   // byte on the data line for the current output count
   always_comb begin
      case (op_q)
         OP_DEV: out_byte = ID_DEVICE; // RULE1
         OP_MFR: out_byte = (out_cnt_q[3] ^ swap_q) ? ID_DEVICE : ID_MFR; // RULE6
         OP_UID: out_byte = ID_UNIQUE[6'(63 - 8 * out_cnt_q[5:3]) -: 8]; // RULE7
         default: begin
            case (out_cnt_q[6:3]) // RULE8
               4'h0: out_byte = ID_MFR;
               4'h1: out_byte = ID_MEM_TYPE;
               4'h2: out_byte = ID_CAPACITY;
               default: out_byte = 8'h00;
            endcase
         end
      endcase
      out_bit = out_byte[3'h7 - out_cnt_q[2:0]]; // RULE4
   end

   // frame sequencing
   always_comb begin
      st_d = st_q;
      op_d = op_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      out_cnt_d = out_cnt_q;
      io1_d = io1_q;
      oe_d = oe_q;
      addr_nz_d = addr_nz_q;
      swap_d = swap_q;
      cont_d = cont_q;
      dual_d = dual_q;
      wake_pend_d = wake_pend_q;
      wake_d = 1'b0;
      frame_d = 1'b0;
      if (link.cs_n) begin
         // end of frame: release line, finish a pending wake
         st_d = DS_IDLE;
         oe_d = 1'b0;
         cnt_d = 6'h00;
         wake_d = wake_pend_q & (st_q != DS_IDLE); // RULE2
         wake_pend_d = 1'b0;
      end else begin
         case (st_q)
            DS_IDLE: begin
               st_d = DS_CMD;
               cnt_d = 6'h00;
               out_cnt_d = 7'h00;
               addr_nz_d = 1'b0;
               swap_d = 1'b0;
               frame_d = cont_q; // RULE9
            end
            DS_CMD: begin
               if (rise) begin
                  shift_d = cmd[6:0]; // RULE16
                  cnt_d = cnt_inc;
                  if (cont_q) begin
                     if (!link.io0) begin
                        st_d = DS_DROP; // RULE10
                     end else if (cnt_inc == (dual_q ? MODE_RST_DUAL :
                                              MODE_RST_QUAD)) begin
                        cont_d = 1'b0; // RULE12 RULE13
                        st_d = DS_DROP;
                     end
                  end else if (cnt_inc == CMD_BITS) begin
                     st_d = DS_DROP;
                     if (i_busy) begin
                        st_d = DS_DROP; // RULE3
                     end else if (cmd == CMD_WAKE_ID) begin
                        st_d = DS_HDR;
                        op_d = OP_DEV;
                        wake_pend_d = i_power_down;
                     end else if (i_power_down) begin
                        st_d = DS_DROP; // RULE15
                     end else if (cmd == CMD_MFR_DEV) begin
                        st_d = DS_HDR;
                        op_d = OP_MFR;
                     end else if (cmd == CMD_UNIQUE) begin
                        st_d = DS_HDR;
                        op_d = OP_UID;
                     end else if (cmd == CMD_STD_ID) begin
                        st_d = DS_OUT;
                        op_d = OP_STD;
                     end
                  end
               end
            end
            DS_HDR: begin
               if (rise) begin
                  cnt_d = cnt_inc; // RULE16
                  if (cnt_q == ADDR_LAST) begin
                     swap_d = ~addr_nz_q & link.io0; // RULE5
                  end else begin
                     addr_nz_d = addr_nz_q | link.io0;
                  end
                  if (cnt_inc == hdr_len) begin
                     st_d = DS_OUT;
                  end
               end
            end
            DS_OUT: begin
               if (fall) begin
                  io1_d = out_bit; // RULE1 RULE6
                  oe_d = 1'b1;
                  out_cnt_d = out_cnt_q + 7'h01;
               end
            end
            DS_DROP: begin
               oe_d = 1'b0;
            end
            default: begin
               st_d = DS_IDLE;
            end
         endcase
      end
      // mode bits from the read engine; a new setting wins
      if (i_mode_valid) begin
         cont_d = (i_mode_bits[7:4] == MODE_KEEP_NIBBLE); // RULE9
         dual_d = i_mode_dual;
      end
   end

   // state registers
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_q <= DS_IDLE;
         op_q <= OP_DEV;
         sclk_q <= 1'b0;
         cnt_q <= 6'h00;
         shift_q <= 7'h00;
         out_cnt_q <= 7'h00;
         io1_q <= 1'b0;
         oe_q <= 1'b0;
         addr_nz_q <= 1'b0;
         swap_q <= 1'b0;
         cont_q <= 1'b0;
         dual_q <= 1'b0;
         wake_pend_q <= 1'b0;
         wake_q <= 1'b0;
         frame_q <= 1'b0;
      end else begin
         st_q <= st_d;
         op_q <= op_d;
         sclk_q <= link.sclk;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         out_cnt_q <= out_cnt_d;
         io1_q <= io1_d;
         oe_q <= oe_d;
         addr_nz_q <= addr_nz_d;
         swap_q <= swap_d;
         cont_q <= cont_d;
         dual_q <= dual_d;
         wake_pend_q <= wake_pend_d;
         wake_q <= wake_d;
         frame_q <= frame_d;
      end
   end

   // outputs
   assign link.io1 = io1_q;
   assign link.io1_oe = oe_q;
   assign o_wake = wake_q;
   assign o_cont_mode = cont_q;
   assign o_cont_frame = frame_q;
endmodule // sfi_flash_end
`default_nettype wire

// [sfi_host_end.sv]
/*
 holds the host end: sends a header, reads bytes back, keeps chip
 select high for the recovery time after every frame, and sends the
 continuous mode reset first after its own reset.
 assumes the flash end shares i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sfi_host_end
   import sfi_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   sfi_link_if.host link,
   input wire logic i_start,
   input wire logic [39:0] i_hdr,
   input wire logic [5:0] i_hdr_bits,
   input wire logic [7:0] i_rd_bytes,
   output logic o_ready,
   output logic [7:0] o_rx_byte,
   output logic o_rx_valid
);
   sfi_host_st_t st_q, st_d;
   logic [3:0] div_q, div_d;
   logic [11:0] gap_q, gap_d;
   logic [11:0] bcnt_q, bcnt_d;
   logic [11:0] total_q, total_d;
   logic [11:0] hbits_q, hbits_d;
   logic [39:0] hdr_q, hdr_d;
   logic [7:0] rx_q, rx_d;
   logic [7:0] byte_q, byte_d;
   logic valid_q, valid_d;
   logic sclk_q, sclk_d;
   logic cs_n_q, cs_n_d;
   logic first_q, first_d;
   logic tick;
   logic [11:0] rd_idx;

   assign tick = (div_q == HALF_PERIOD - 4'h1);
   assign rd_idx = bcnt_q - hbits_q;

   // frame sequencing and serial clock
   always_comb begin
      st_d = st_q;
      div_d = tick ? 4'h0 : div_q + 4'h1;
      gap_d = gap_q;
      bcnt_d = bcnt_q;
      total_d = total_q;
      hbits_d = hbits_q;
      hdr_d = hdr_q;
      rx_d = rx_q;
      byte_d = byte_q;
      valid_d = 1'b0;
      sclk_d = sclk_q;
      cs_n_d = cs_n_q;
      first_d = first_q;
      case (st_q)
         HS_IDLE: begin
            div_d = 4'h0;
            bcnt_d = 12'h000;
            if (first_q) begin
               // mode reset: sixteen ones cover dual and quad
               hdr_d = {CMD_MODE_RST, CMD_MODE_RST, 24'h000000}; // RULE11
               hbits_d = {6'h00, MODE_RST_DUAL}; // RULE12 RULE13
               total_d = {6'h00, MODE_RST_DUAL};
               first_d = 1'b0;
               cs_n_d = 1'b0;
               st_d = HS_LEAD;
            end else if (i_start) begin
               hdr_d = i_hdr;
               hbits_d = {6'h00, i_hdr_bits};
               total_d = {6'h00, i_hdr_bits} + {1'b0, i_rd_bytes, 3'h0};
               cs_n_d = 1'b0;
               st_d = HS_LEAD;
            end
         end
         HS_LEAD: begin
            if (tick) begin
               st_d = HS_SHIFT;
            end
         end
         HS_SHIFT: begin
            if (tick && !sclk_q) begin
               // rising edge: flash samples io0, host samples io1
               sclk_d = 1'b1;
               bcnt_d = bcnt_q + 12'h001;
               if (bcnt_q >= hbits_q) begin
                  rx_d = {rx_q[6:0], link.io1};
                  if (rd_idx[2:0] == 3'h7) begin
                     byte_d = {rx_q[6:0], link.io1};
                     valid_d = 1'b1;
                  end
               end
            end else if (tick && sclk_q) begin
               // falling edge: next header bit or end of frame
               sclk_d = 1'b0;
               hdr_d = {hdr_q[38:0], 1'b0};
               if (bcnt_q == total_q) begin
                  cs_n_d = 1'b1; // RULE1 RULE6
                  gap_d = 12'h000;
                  st_d = HS_GAP;
               end
            end
         end
         HS_GAP: begin
            gap_d = gap_q + 12'h001;
            if (gap_q == RECOV_CYCLES - 12'h001) begin
               st_d = HS_IDLE; // RULE2
            end
         end
         default: begin
            st_d = HS_IDLE;
            cs_n_d = 1'b1;
            sclk_d = 1'b0;
         end
      endcase
   end

   // state registers
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_q <= HS_IDLE;
         div_q <= 4'h0;
         gap_q <= 12'h000;
         bcnt_q <= 12'h000;
         total_q <= 12'h000;
         hbits_q <= 12'h000;
         hdr_q <= 40'h00_0000_0000;
         rx_q <= 8'h00;
         byte_q <= 8'h00;
         valid_q <= 1'b0;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         first_q <= 1'b1;
      end else begin
         st_q <= st_d;
         div_q <= div_d;
         gap_q <= gap_d;
         bcnt_q <= bcnt_d;
         total_q <= total_d;
         hbits_q <= hbits_d;
         hdr_q <= hdr_d;
         rx_q <= rx_d;
         byte_q <= byte_d;
         valid_q <= valid_d;
         sclk_q <= sclk_d;
         cs_n_q <= cs_n_d;
         first_q <= first_d;
      end
   end

   // outputs
   assign link.cs_n = cs_n_q;
   assign link.sclk = sclk_q;
   assign link.io0 = hdr_q[39]; // RULE4 RULE7 RULE14
   assign o_ready = (st_q == HS_IDLE) & ~first_q;
   assign o_rx_byte = byte_q;
   assign o_rx_valid = valid_q;
endmodule // sfi_host_end
`default_nettype wire

// [sfi_props.sv]
/*
 holds the link checker: timing relations on the shared serial link.
 assumes one system clock and is instantiated beside the link.
*/
`timescale 1ns/1ps
`default_nettype none
module sfi_props
   import sfi_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic io0,
   input wire logic io1,
   input wire logic io1_oe
);
   logic [11:0] hi_cnt_q, hi_cnt_d;
   logic first_q, first_d, cs_q, cs_d;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   // select high time and first-frame flag
   always_comb begin
      hi_cnt_d = 12'h000;
      if (cs_n) begin
         hi_cnt_d = (hi_cnt_q == 12'hfff) ? hi_cnt_q : hi_cnt_q + 12'h001;
      end
      cs_d = cs_n;
      first_d = first_q & ~(cs_n & ~cs_q);
   end

   // helper registers
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         hi_cnt_q <= 12'hfff;
         first_q <= 1'b1;
         cs_q <= 1'b1;
      end else begin
         hi_cnt_q <= hi_cnt_d;
         first_q <= first_d;
         cs_q <= cs_d;
      end
   end

   property p_recovery;
      $fell(cs_n) |-> (hi_cnt_q >= RECOV_CYCLES);
   endproperty
   a_recovery: assert property (p_recovery)
      else $error("select high time too short");
   property p_first_ones;
      first_q && $rose(sclk) |-> io0;
   endproperty
   a_first_ones: assert property (p_first_ones)
      else $error("first frame not all ones");
   property p_sclk_idle;
      cs_n |-> !sclk;
   endproperty
   a_sclk_idle: assert property (p_sclk_idle)
      else $error("serial clock active outside frame");
   property p_cs_setup;
      $fell(cs_n) |-> !sclk ##1 !sclk;
   endproperty
   a_cs_setup: assert property (p_cs_setup)
      else $error("clock rose too soon after select");
   property p_sclk_hi;
      $rose(sclk) |=> sclk;
   endproperty
   a_sclk_hi: assert property (p_sclk_hi)
      else $error("serial clock high too short");
   property p_io0_hold;
      sclk |-> $stable(io0);
   endproperty
   a_io0_hold: assert property (p_io0_hold)
      else $error("host data moved while clock high");
   property p_oe_off;
      cs_n && $past(cs_n) |-> !io1_oe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("flash drives after frame end");
   property p_oe_rise;
      $rose(io1_oe) |-> !sclk && !cs_n;
   endproperty
   a_oe_rise: assert property (p_oe_rise)
      else $error("output enable rose outside clock low");
   property p_io1_hold;
      io1_oe && sclk |-> $stable(io1);
   endproperty
   a_io1_hold: assert property (p_io1_hold)
      else $error("flash data moved while clock high");
   property p_io1_edge;
      !cs_n && io1_oe && $past(io1_oe) && $changed(io1) |->
         (!$past(sclk) && $past(sclk, 2)) ||
         (!$past(sclk, 2) && $past(sclk, 3));
   endproperty
   a_io1_edge: assert property (p_io1_edge)
      else $error("flash data changed away from falling edge");

   c_out: cover property ($rose(io1_oe));
   c_first: cover property (first_q && $rose(sclk));
   c_frame: cover property ($fell(cs_n));
endmodule // sfi_props
`default_nettype wire

// [sfi_test.sv]
/*
 holds the self-checking bench: host and flash ends joined by the link,
 identification frames run through the host, flash side inputs driven.
 assumes the package constants and a 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sfi_test
   import sfi_pkg::*;
();
   logic i_clk = 1'b0, i_rst_n = 1'b0, start = 1'b0, ready, rx_valid;
   logic [39:0] hdr = 40'h0;
   logic [5:0] hdr_bits = 6'h00;
   logic [7:0] rd_bytes = 8'h00, rx_byte, mode_bits = 8'h00;
   logic busy = 1'b0, pdown = 1'b0, mode_valid = 1'b0, mode_dual = 1'b0;
   logic wake, cont_mode, cont_frame;
   logic oe_seen = 1'b0, wake_seen = 1'b0, cf_seen = 1'b0, clr_seen = 1'b0;
   int bad_count = 0, compares = 0;

   sfi_link_if link();
   sfi_host_end sfi_host_end_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .link(link), .i_start(start), .i_hdr(hdr), .i_hdr_bits(hdr_bits),
      .i_rd_bytes(rd_bytes), .o_ready(ready), .o_rx_byte(rx_byte),
      .o_rx_valid(rx_valid));
   sfi_flash_end sfi_flash_end_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .link(link), .i_busy(busy), .i_power_down(pdown),
      .i_mode_valid(mode_valid), .i_mode_bits(mode_bits),
      .i_mode_dual(mode_dual), .o_wake(wake), .o_cont_mode(cont_mode),
      .o_cont_frame(cont_frame));
   sfi_props sfi_props_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .cs_n(link.cs_n), .sclk(link.sclk), .io0(link.io0), .io1(link.io1),
      .io1_oe(link.io1_oe));

   // clock
   initial begin
      forever #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;
   end

   // sticky flags of flash pulses, cleared as each frame starts
   always @(posedge i_clk) begin
      if (clr_seen) begin
         oe_seen <= 1'b0;
         wake_seen <= 1'b0;
         cf_seen <= 1'b0;
      end else begin
         if (link.io1_oe === 1'b1) oe_seen <= 1'b1;
         if (wake === 1'b1) wake_seen <= 1'b1;
         if (cont_frame === 1'b1) cf_seen <= 1'b1;
      end
   end

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [63:0] exp,
                        input logic [63:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one host frame, bytes compared msb-aligned against exp
   task automatic frame(input logic [39:0] h, input logic [5:0] nb,
      input logic [7:0] nr, input logic [63:0] exp, input bit chk);
      int k, t;
      k = 0;
      t = 0;
      while (ready !== 1'b1 && t < 4000) begin
         @(negedge i_clk);
         t++;
      end
      if (t >= 4000) begin
         bad_count++;
         tally_and_finish();
      end
      clr_seen = 1'b1;
      start = 1'b1;
      hdr = h;
      hdr_bits = nb;
      rd_bytes = nr;
      @(negedge i_clk);
      start = 1'b0;
      clr_seen = 1'b0;
      t = 0;
      while (ready !== 1'b1 && t < 20000) begin
         if (rx_valid === 1'b1 && chk && k < 8) begin
            check("rx_byte", {56'h0, exp[63-8*k -: 8]}, {56'h0, rx_byte});
            k++;
         end
         @(negedge i_clk);
         t++;
      end
      if (t >= 20000) begin
         bad_count++;
         tally_and_finish();
      end
      if (chk) check("byte count", {56'h0, nr}, 64'(k));
   endtask

   task automatic set_mode(input logic [7:0] b, input logic d);
      mode_valid = 1'b1;
      mode_bits = b;
      mode_dual = d;
      @(negedge i_clk);
      mode_valid = 1'b0;
      @(negedge i_clk);
   endtask

   // main sequence
   initial begin
      repeat (8) @(negedge i_clk);
      i_rst_n = 1'b1;
      frame({CMD_WAKE_ID, 32'h0}, HDR_WAKE_ID, 8'h03,
            {ID_DEVICE, ID_DEVICE, ID_DEVICE, 40'h0}, 1'b1);
      $display("test device id done");
      frame({CMD_MFR_DEV, 32'h0}, HDR_MFR_DEV, 8'h04,
            {ID_MFR, ID_DEVICE, ID_MFR, ID_DEVICE, 32'h0}, 1'b1);
      frame({CMD_MFR_DEV, 24'h000001, 8'h0}, HDR_MFR_DEV, 8'h03,
            {ID_DEVICE, ID_MFR, ID_DEVICE, 40'h0}, 1'b1);
      frame({CMD_MFR_DEV, 24'h000003, 8'h0}, HDR_MFR_DEV, 8'h02,
            {ID_MFR, ID_DEVICE, 48'h0}, 1'b1);
      $display("test manufacturer and device done");
      frame({CMD_UNIQUE, 32'h0}, HDR_UNIQUE, 8'h08, ID_UNIQUE, 1'b1);
      frame({CMD_STD_ID, 32'h0}, HDR_STD_ID, 8'h04,
            {ID_MFR, ID_MEM_TYPE, ID_CAPACITY, 40'h0}, 1'b1);
      $display("test unique and standard id done");
      busy = 1'b1;
      frame({CMD_WAKE_ID, 32'h0}, HDR_WAKE_ID, 8'h01, 64'h0, 1'b0);
      check("busy io1_oe", 64'h0, {63'h0, oe_seen});
      busy = 1'b0;
      pdown = 1'b1;
      frame({CMD_STD_ID, 32'h0}, HDR_STD_ID, 8'h01, 64'h0, 1'b0);
      check("power-down io1_oe", 64'h0, {63'h0, oe_seen});
      frame({CMD_WAKE_ID, 32'h0}, HDR_WAKE_ID, 8'h01,
            {ID_DEVICE, 56'h0}, 1'b1);
      check("wake", 64'h1, {63'h0, wake_seen});
      pdown = 1'b0;
      $display("test busy and power-down done");
      set_mode(8'ha5, 1'b0);
      check("cont_mode set", 64'h1, {63'h0, cont_mode});
      set_mode(8'h5a, 1'b0);
      check("cont_mode clear", 64'h0, {63'h0, cont_mode});
      set_mode(8'ha5, 1'b0);
      check("cont_mode again", 64'h1, {63'h0, cont_mode});
      frame({CMD_STD_ID, 32'h0}, HDR_STD_ID, 8'h02, 64'h0, 1'b0);
      check("cont io1_oe", 64'h0, {63'h0, oe_seen});
      check("cont_frame", 64'h1, {63'h0, cf_seen});
      frame({8'hff, 32'h0}, MODE_RST_QUAD, 8'h00, 64'h0, 1'b0);
      check("quad exit", 64'h0, {63'h0, cont_mode});
      set_mode(8'ha0, 1'b1);
      frame({8'hff, 32'h0}, MODE_RST_QUAD, 8'h00, 64'h0, 1'b0);
      check("dual short", 64'h1, {63'h0, cont_mode});
      frame({16'hffff, 24'h0}, MODE_RST_DUAL, 8'h00, 64'h0, 1'b0);
      check("dual exit", 64'h0, {63'h0, cont_mode});
      $display("test continuous mode done");
      tally_and_finish();
   end
endmodule // sfi_test
`default_nettype wire
